// File: pkg/axs_pkg.sv
// How it works
// - Register-minus-accumulator subtract, two's complement, 8-bit difference to destination.
// - Destination bit 0 writes accumulator; 1 writes back the addressed register, except for literal XOR.
// - Register XOR with accumulator at 7-bit address; only zero flag changes.
// - Nibble exchange swaps register halves; no flag changes.
// - Exchange with destination set rewrites register; clear sends result to accumulator only.
// - Literal XOR with accumulator always lands in accumulator; only zero flag changes.
// - Subtract minuend is the register, subtrahend the accumulator, never reversed.
package axs_pkg;

    // ------------------------------------------------------------
    // Bus map
    // ------------------------------------------------------------
    localparam int ADR_W = 10;
    localparam logic [ADR_W-1:0] OFS_ACC = 10'h000;
    localparam logic [ADR_W-1:0] OFS_STATUS = 10'h004;
    localparam logic [ADR_W-1:0] OFS_CMD = 10'h008;
    localparam logic [ADR_W-1:0] OFS_RESULT = 10'h00c;
    localparam int MEM_SEL_BIT = 9;
    localparam int MEM_IDX_LO = 2;
    localparam int REG_AW = 7;
    localparam int REG_DEPTH = 128;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int STAT_C_BIT = 0;
    localparam int STAT_DC_BIT = 1;
    localparam int STAT_Z_BIT = 2;
    localparam int CMD_W = 18;
    localparam logic [7:0] ACC_RST = 8'h00;

    typedef enum logic [1:0] {
        sub_acc_from_reg_op,
        xor_acc_reg_op,
        nibble_exchange_op,
        xor_acc_literal_op
    } axs_op_e;

    // Command word as written to OFS_CMD, op in the low bits
    typedef struct packed {
        logic [7:0] literal;
        logic [REG_AW-1:0] addr;
        logic dest;
        axs_op_e op;
    } axs_cmd_s;

    typedef struct packed {
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } axs_flags_s;

    typedef struct packed {
        logic [7:0] res;
        axs_flags_s flg;
    } axs_alu_s;

endpackage : axs_pkg

// File: rtl/axs_byte_mem.sv
`timescale 1ns/1ns
module axs_byte_mem #(
    parameter int AW = 7,
    parameter int DEPTH = 128
) (
    input wire logic clk_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);

    logic [7:0] mem_r [DEPTH];

    generate
        if (DEPTH != (1 << AW))
        begin : g_chk
            $error("axs_byte_mem: DEPTH must equal 2**AW");
        end
    endgenerate

    // Read-first: a write shows its new value one access later
    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem_r[addr_i] <= wdata_i;
        end
        rdata_o <= mem_r[addr_i];
    end

endmodule : axs_byte_mem

// File: rtl/axs_alu_top.sv
`timescale 1ns/1ns
module axs_alu_top #(
    parameter int DEPTH = axs_pkg::REG_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [axs_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    typedef enum logic [1:0] {st_idle, st_memrd, st_fetch} axs_state_e;

    // ------------------------------------------------------------
    // Datapath function
    // ------------------------------------------------------------
    function automatic axs_pkg::axs_alu_s alu(input axs_pkg::axs_cmd_s cmd, input logic [7:0] f,
                                              input logic [7:0] w, input axs_pkg::axs_flags_s fl);
        axs_pkg::axs_alu_s o;
        logic [8:0] d;
        logic [4:0] dn;
        o.flg = fl;
        d = {1'b0, f} + {1'b0, ~w} + 9'h001;
        dn = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        case (cmd.op)
            axs_pkg::sub_acc_from_reg_op:
            begin
                o.res = d[7:0];
                o.flg.carry_flag = d[8];
                o.flg.digit_carry_flag = dn[4];
                o.flg.zero_flag = (d[7:0] == 8'h00);
            end
            axs_pkg::xor_acc_reg_op:
            begin
                o.res = w ^ f;
                o.flg.zero_flag = (o.res == 8'h00);
            end
            axs_pkg::nibble_exchange_op:
            begin
                o.res = {f[3:0], f[7:4]};
            end
            default:
            begin
                o.res = w ^ cmd.literal;
                o.flg.zero_flag = (o.res == 8'h00);
            end
        endcase
        return o;
    endfunction : alu

    function automatic logic is_mem(input logic [axs_pkg::ADR_W-1:0] a);
        return a[axs_pkg::MEM_SEL_BIT];
    endfunction : is_mem

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    axs_state_e state_r, state_nxt;
    logic [7:0] acc_r, acc_nxt;
    logic [7:0] result_r, result_nxt;
    axs_pkg::axs_flags_s flags_r, flags_nxt;
    axs_pkg::axs_cmd_s cmd_r, cmd_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic [axs_pkg::REG_AW-1:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rd;
    axs_pkg::axs_alu_s alu_out;
    logic req;
    logic [7:0] lit;

    generate
        if (DEPTH != axs_pkg::REG_DEPTH)
        begin : g_chk
            $error("axs_alu_top: DEPTH must match the 7-bit register address");
        end
    endgenerate

    axs_byte_mem #(
        .AW(axs_pkg::REG_AW),
        .DEPTH(DEPTH)
    ) u_mem (
        .clk_i(clk_i),
        .addr_i(mem_addr),
        .we_i(mem_we),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rd)
    );

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign alu_out = alu(cmd_r, mem_rd, acc_r, flags_r);
    assign lit = cmd_r.literal;

    // ------------------------------------------------------------
    // Bus slave and execution sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        acc_nxt = acc_r;
        result_nxt = result_r;
        flags_nxt = flags_r;
        cmd_nxt = cmd_r;
        dat_nxt = dat_r;
        ack_nxt = 1'b0;
        mem_addr = cmd_r.addr;
        mem_we = 1'b0;
        mem_wdata = wb_dat_i[7:0];
        case (state_r)
            st_idle:
            begin
                if (req && is_mem(wb_adr_i))
                begin
                    mem_addr = wb_adr_i[axs_pkg::MEM_IDX_LO +: axs_pkg::REG_AW];
                    if (wb_we_i)
                    begin
                        mem_we = wb_sel_i[0];
                        ack_nxt = 1'b1;
                    end
                    else
                    begin
                        state_nxt = st_memrd;
                    end
                end
                else if (req)
                begin
                    ack_nxt = 1'b1;
                    dat_nxt = 32'h0000_0000;
                    if (wb_adr_i == axs_pkg::OFS_ACC)
                    begin
                        dat_nxt[7:0] = acc_r;
                        if (wb_we_i && wb_sel_i[0])
                        begin
                            acc_nxt = wb_dat_i[7:0];
                        end
                    end
                    else if (wb_adr_i == axs_pkg::OFS_STATUS)
                    begin
                        dat_nxt[axs_pkg::STAT_C_BIT] = flags_r.carry_flag;
                        dat_nxt[axs_pkg::STAT_DC_BIT] = flags_r.digit_carry_flag;
                        dat_nxt[axs_pkg::STAT_Z_BIT] = flags_r.zero_flag;
                        if (wb_we_i && wb_sel_i[0])
                        begin
                            flags_nxt.carry_flag = wb_dat_i[axs_pkg::STAT_C_BIT];
                            flags_nxt.digit_carry_flag = wb_dat_i[axs_pkg::STAT_DC_BIT];
                            flags_nxt.zero_flag = wb_dat_i[axs_pkg::STAT_Z_BIT];
                        end
                    end
                    else if (wb_adr_i == axs_pkg::OFS_CMD)
                    begin
                        dat_nxt[axs_pkg::CMD_W-1:0] = cmd_r;
                        // Partial command writes are dropped: a torn command could hit the wrong register
                        if (wb_we_i && (wb_sel_i[2:0] == 3'h7))
                        begin
                            cmd_nxt = axs_pkg::axs_cmd_s'(wb_dat_i[axs_pkg::CMD_W-1:0]);
                            mem_addr = cmd_nxt.addr;
                            ack_nxt = 1'b0;
                            state_nxt = st_fetch;
                        end
                    end
                    else if (wb_adr_i == axs_pkg::OFS_RESULT)
                    begin
                        dat_nxt[7:0] = result_r;
                    end
                end
            end
            st_memrd:
            begin
                mem_addr = wb_adr_i[axs_pkg::MEM_IDX_LO +: axs_pkg::REG_AW];
                dat_nxt = {24'h00_0000, mem_rd};
                ack_nxt = 1'b1;
                state_nxt = st_idle;
            end
            default:
            begin
                // Operand is valid now; write back and answer the command write
                result_nxt = alu_out.res;
                flags_nxt = alu_out.flg;
                if (cmd_r.dest && (cmd_r.op != axs_pkg::xor_acc_literal_op))
                begin
                    mem_we = 1'b1;
                    mem_wdata = alu_out.res;
                end
                else
                begin
                    acc_nxt = alu_out.res;
                end
                ack_nxt = 1'b1;
                state_nxt = st_idle;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= st_idle;
            acc_r <= axs_pkg::ACC_RST;
            result_r <= axs_pkg::ACC_RST;
            flags_r <= '0;
            cmd_r <= '0;
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            result_r <= result_nxt;
            flags_r <= flags_nxt;
            cmd_r <= cmd_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_sub_diff: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::sub_acc_from_reg_op && !cmd_r.dest)
        |=> acc_r == 8'($past(mem_rd) - $past(acc_r)))
        else $error("subtract result wrong");

    a_sub_order: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::sub_acc_from_reg_op && !cmd_r.dest
         && 8'(mem_rd - acc_r) != 8'(acc_r - mem_rd))
        |=> acc_r != 8'($past(acc_r) - $past(mem_rd)))
        else $error("subtract operands reversed");

    a_dest_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.dest && cmd_r.op != axs_pkg::xor_acc_literal_op)
        |-> mem_we ##1 (acc_r == $past(acc_r)) && ack_r)
        else $error("register destination disturbed accumulator");

    a_sub_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::sub_acc_from_reg_op)
        |=> flags_r.carry_flag == ($past(acc_r) <= $past(mem_rd))
            && flags_r.digit_carry_flag == ($past(acc_r[3:0]) <= $past(mem_rd[3:0])))
        else $error("subtract carry flags wrong");

    a_xor_reg: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::xor_acc_reg_op)
        |=> result_r == ($past(acc_r) ^ $past(mem_rd)) && flags_r.carry_flag == $past(flags_r.carry_flag)
            && flags_r.digit_carry_flag == $past(flags_r.digit_carry_flag)
            && flags_r.zero_flag == (result_r == 8'h00))
        else $error("register xor wrong");

    a_swap_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::nibble_exchange_op)
        |=> flags_r == $past(flags_r) && result_r == {$past(mem_rd[3:0]), $past(mem_rd[7:4])})
        else $error("nibble exchange wrong");

    a_swap_dest: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::nibble_exchange_op)
        |-> (mem_we == cmd_r.dest) && (!cmd_r.dest || mem_wdata == {mem_rd[3:0], mem_rd[7:4]}))
        else $error("nibble exchange destination wrong");

    a_xor_lit: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_r == st_fetch && cmd_r.op == axs_pkg::xor_acc_literal_op)
        |-> !mem_we ##1 acc_r == ($past(acc_r) ^ $past(lit)) && flags_r.carry_flag == $past(flags_r.carry_flag))
        else $error("literal xor wrong");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");

endmodule : axs_alu_top

// File: verification/axs_wb_host.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// Bus master standing in for the instruction decoder
// ------------------------------------------------------------
module axs_wb_host (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [axs_pkg::ADR_W-1:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial
    begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = '0;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // On release the address and data lines show inverted values so stale data never looks valid
    // Waits for ack with no limit of its own; only the bench watchdog ends a hang
    task automatic xfer(input logic we, input logic [axs_pkg::ADR_W-1:0] adr, input logic [31:0] d,
                        input logic [3:0] sel, output logic [31:0] q);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= d;
        do
        begin
            @(posedge clk_i);
        end
        while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~adr;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask : xfer
endmodule : axs_wb_host

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    int fails = 0;
    int check_count = 0;
    logic [31:0] expq[$];
    logic [7:0] acc;
    logic [2:0] flg;
    logic [7:0] mem [128];
    logic [7:0] bav [6] = '{8'h05, 8'h06, 8'h0f, 8'h10, 8'h00, 8'hff};
    logic [7:0] brv [6] = '{8'h05, 8'h05, 8'h10, 8'h0f, 8'hff, 8'h00};

    always #10 clk_i = ~clk_i;

    axs_alu_top #(.DEPTH(128)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    axs_wb_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t read %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge clk_i)
        if (ack === 1'b1 && we === 1'b0 && cyc === 1'b1)
        begin
            if (expq.size() == 0)
                check(rdat, 32'hxxxxxxxx);
            else
                check(rdat, expq.pop_front());
        end

    task automatic complete_run;
        if (expq.size() != 0)
            fails++;
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Bus helpers and operation model
    // ------------------------------------------------------------
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        host.xfer(1'b1, a, d, 4'hf, q);
    endtask : wr

    task automatic wr_sel(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        host.xfer(1'b1, a, d, s, q);
    endtask : wr_sel

    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        logic [31:0] q;
        expq.push_back(e);
        host.xfer(1'b0, a, 32'h0, 4'hf, q);
    endtask : rd

    // Flags are preset randomly so untouched bits are really seen to hold
    task automatic run_op(input logic [1:0] op, input logic d, input logic [6:0] a, input logic [7:0] lit,
                          input logic [7:0] av, input logic [7:0] rv);
        logic [7:0] r;
        logic [17:0] cmd;
        acc = av;
        mem[a] = rv;
        flg = 3'($urandom);
        cmd = {lit, a, d, op};
        wr(10'h000, {24'h0, av});
        wr({1'b1, a, 2'b00}, {24'h0, rv});
        wr(10'h004, {29'h0, flg});
        wr(10'h008, {14'h0, cmd});
        r = (op == 2'd0) ? rv - av : (op == 2'd1) ? av ^ rv : (op == 2'd2) ? {rv[3:0], rv[7:4]} : av ^ lit;
        if (op == 2'd0)
            flg[1:0] = {av[3:0] <= rv[3:0], av <= rv};
        if (op != 2'd2)
            flg[2] = (r == 8'h00);
        if (d && op != 2'd3)
            mem[a] = r;
        else
            acc = r;
        rd(10'h00c, {24'h0, r});
        rd(10'h000, {24'h0, acc});
        rd(10'h004, {29'h0, flg});
        rd({1'b1, a, 2'b00}, {24'h0, mem[a]});
        rd(10'h008, {14'h0, cmd});
    endtask : run_op

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h4126));
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(10'h000, 32'h0);
        rd(10'h004, 32'h0);
        rd(10'h008, 32'h0);
        rd(10'h00c, 32'h0);
        wr(10'h010, 32'hffffffff);
        rd(10'h010, 32'h0);
        // Borrow edges: equal, one above, nibble crossing, full range
        for (int i = 0; i < 6; i++)
            run_op(2'd0, i[0], (i == 5) ? 7'h7f : 7'(i), 8'h00, bav[i], brv[i]);
        // Partial command and memory writes are acked but must change nothing
        wr_sel(10'h008, {14'h0, 8'h5a, 7'h7f, 1'b0, 2'd3}, 4'h3);
        rd(10'h008, {14'h0, 8'h00, 7'h7f, 1'b1, 2'd0});
        rd(10'h000, {24'h0, acc});
        wr_sel({1'b1, 7'h7f, 2'b00}, 32'h0000_0011, 4'he);
        rd({1'b1, 7'h7f, 2'b00}, {24'h0, mem[7'h7f]});
        for (int i = 0; i < 48; i++)
            run_op(2'(i), i[2], 7'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
        complete_run;
    end

    initial
    begin
        #(20 * 30000);
        fails++;
        complete_run;
    end
endmodule : tb
